// ==== core/stpdrv_top.sv ====
// Step and direction translator with two PWM current regulators.
// Function
// - Decode three resolution bits into eight modes.
// - Reset loads home levels and mixed decay.
// - Each step rising edge advances one increment, half of one in full-step modes from an axis.
// - Resolution code latched only on step edge.
// - Direction sampled only on step edge.
// - Direction low clockwise, high counterclockwise.
// - Reset input holds home, outputs off.
// - Step pulses ignored while reset input low.
// - Thermal or overcurrent event returns home.
// - Drive diagonal pair until sense meets level.
// - Latch reset drops source or reverses whole bridge.
// - Grounded pin: adaptive fast decay, 16 us.
// - High pin: slow rise, mixed fall, 30 us.
// - Resistor pin: off-time equals ohms over 825.
// - Blank comparators about 1 us after switching.
// - Trip level is table percent of full scale.
// - Full-torque modes use full or zero current.
// - Enable high turns outputs off, translator active.
// - Sleep low powers down, wake returns home.
module stpdrv_top
	import stpdrv_pkg::*;
(
	// Clock and reset.
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	// Translator inputs.
	input  wire logic         step_in,
	input  wire logic         dir_in,
	input  wire logic         res_sel_bit0,
	input  wire logic         res_sel_bit1,
	input  wire logic         res_sel_bit2,
	input  wire logic         reset_in_n,
	input  wire logic         disable_out,
	input  wire logic         sleep_n,
	// Protection events.
	input  wire logic         thermal_shutdown,
	input  wire logic         overcurrent,
	// Off-time configuration pin and resistor value in ohms.
	input  wire stpdrv_cfg_t  offtime_config_pin,
	input  wire logic [19:0]  offtime_res_ohms,
	// Comparator results, high when sense voltage reaches the level.
	input  wire logic         sense_trip1,
	input  wire logic         sense_trip2,
	// DAC levels in percent and polarities.
	output logic [LVL_W-1:0]  dac1,
	output logic [LVL_W-1:0]  dac2,
	output logic              neg1,
	output logic              neg2,
	output logic [POS_W-1:0]  position,
	output stpdrv_res_t       res_mode,
	// Gate drives of bridge one and two.
	output logic              b1_src_a,
	output logic              b1_snk_a,
	output logic              b1_src_b,
	output logic              b1_snk_b,
	output logic              b2_src_a,
	output logic              b2_snk_a,
	output logic              b2_src_b,
	output logic              b2_snk_b,
	output stpdrv_decay_t     decay1,
	output stpdrv_decay_t     decay2,
	output logic              overcurrent_latched
);

	logic [POS_W-1:0]  pos_q;
	stpdrv_res_t       res_q;
	logic              step_prev_q;
	logic              ocp_q;
	logic              step_evt;
	logic              go_home;
	logic [2:0]        res_sel_code;
	logic [POS_W-1:0]  inc;
	logic [POS_W-1:0]  pos_d;
	logic [1:0]        evt_q;
	logic              full_torque;
	logic [LVL_W-1:0]  t_lvl1;
	logic [LVL_W-1:0]  t_lvl2;
	logic              t_neg1;
	logic              t_neg2;
	logic [LVL_W-1:0]  dac1_q;
	logic [LVL_W-1:0]  dac2_q;
	logic              neg1_q;
	logic              neg2_q;
	logic              rise1_q;
	logic              rise2_q;
	logic              run;
	logic [CNT_W-1:0]  off_cyc;
	logic [31:0]       res_cyc;
	logic [CNT_W-1:0]  res_off;

	assign res_sel_code = {res_sel_bit2, res_sel_bit1, res_sel_bit0};
	// Thermal and overcurrent events, sleep and reset all force home.
	assign go_home  = !reset_in_n || !sleep_n || thermal_shutdown
		|| overcurrent;
	assign step_evt = step_in && !step_prev_q && !go_home;

	// Step edge detector; the pulse widths are the controller's duty.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			step_prev_q <= 1'b0;
		end else begin
			step_prev_q <= step_in;
		end
	end

	// Decay choice waits until the new levels show whether current rises.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			evt_q <= 2'h0;
		end else begin
			evt_q <= {evt_q[0], step_evt};
		end
	end

	// Increment size in 1/32 steps for the code taken at the edge.
	always_comb begin
		unique case (stpdrv_res_t'(res_sel_code))
			STPDRV_FULL:      inc = 7'h20;
			STPDRV_HALF:      inc = 7'h10;
			STPDRV_SIXTEENTH: inc = 7'h02;
			STPDRV_THIRTY2ND: inc = 7'h01;
			STPDRV_FULL_MOD:  inc = 7'h20;
			STPDRV_HALF_MOD:  inc = 7'h10;
			STPDRV_QUARTER:   inc = 7'h08;
			STPDRV_EIGHTH:    inc = 7'h04;
		endcase
	end

	// Full steps sit at 45 degrees, so the first one lands mid-quadrant.
	always_comb begin
		if (!dir_in) begin
			pos_d = pos_q + inc;
		end else begin
			pos_d = pos_q - inc;
		end
		if (inc == 7'h20 && pos_q[4:0] == 5'h00) begin
			pos_d = dir_in ? pos_q - 7'h10 : pos_q + 7'h10;
		end
	end

	// Translator position; home is shared by all resolutions.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pos_q <= HOME_POS;
		end else if (go_home) begin
			pos_q <= HOME_POS;
		end else if (step_evt) begin
			pos_q <= pos_d;
		end
	end

	// Mode is taken at the step edge only, so changes wait for it.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			res_q <= STPDRV_FULL;
		end else if (step_evt) begin
			res_q <= stpdrv_res_t'(res_sel_code);
		end
	end

	assign full_torque = (res_q == STPDRV_FULL) || (res_q == STPDRV_HALF);

	stpdrv_table u_table (
		.pos         (pos_q),
		.full_torque (full_torque),
		.lvl1        (t_lvl1),
		.neg1        (t_neg1),
		.lvl2        (t_lvl2),
		.neg2        (t_neg2)
	);

	// DAC registers also record whether each current magnitude rose.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dac1_q  <= 7'h64;
			dac2_q  <= 7'h00;
			neg1_q  <= 1'b0;
			neg2_q  <= 1'b0;
			rise1_q <= 1'b0;
			rise2_q <= 1'b0;
		end else begin
			dac1_q  <= t_lvl1;
			dac2_q  <= t_lvl2;
			neg1_q  <= t_neg1;
			neg2_q  <= t_neg2;
			rise1_q <= (t_lvl1 > dac1_q) || (t_lvl1 == dac1_q && rise1_q);
			rise2_q <= (t_lvl2 > dac2_q) || (t_lvl2 == dac2_q && rise2_q);
		end
	end

	// Overcurrent latch holds outputs off until sleep or reset input low.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ocp_q <= 1'b0;
		end else if (overcurrent) begin
			ocp_q <= 1'b1;
		end else if (!reset_in_n || !sleep_n) begin
			ocp_q <= 1'b0;
		end
	end

	assign run = reset_in_n && sleep_n && !disable_out && !thermal_shutdown
		&& !ocp_q && !overcurrent;

	// Off-time count chosen by the configuration pin.
	assign res_cyc = (32'(offtime_res_ohms) * NS_PER_US)
		/ (RES_DIVISOR * CLK_NS);

	// An open or shorted resistor must neither stall nor skip the off-time.
	always_comb begin
		if (res_cyc > 32'h0000FFFF) begin
			res_off = 16'hFFFF;
		end else if (res_cyc == 32'h0) begin
			res_off = 16'h0001;
		end else begin
			res_off = res_cyc[CNT_W-1:0];
		end
	end

	always_comb begin
		unique case (offtime_config_pin)
			STPDRV_CFG_GND:      off_cyc = CNT_W'(OFF_GND_CYC);
			STPDRV_CFG_HIGH:     off_cyc = CNT_W'(OFF_HIGH_CYC);
			STPDRV_CFG_RESISTOR: off_cyc = res_off;
			default:             off_cyc = CNT_W'(OFF_HIGH_CYC);
		endcase
	end

	stpdrv_bridge u_br1 (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.run      (run),
		.neg      (neg1_q),
		.trip     (sense_trip1),
		.step_evt (evt_q[1]),
		.home     (go_home),
		.rising   (rise1_q),
		.cfg      (offtime_config_pin),
		.off_cyc  (off_cyc),
		.src_a    (b1_src_a),
		.snk_a    (b1_snk_a),
		.src_b    (b1_src_b),
		.snk_b    (b1_snk_b),
		.decay    (decay1)
	);

	stpdrv_bridge u_br2 (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.run      (run),
		.neg      (neg2_q),
		.trip     (sense_trip2),
		.step_evt (evt_q[1]),
		.home     (go_home),
		.rising   (rise2_q),
		.cfg      (offtime_config_pin),
		.off_cyc  (off_cyc),
		.src_a    (b2_src_a),
		.snk_a    (b2_snk_a),
		.src_b    (b2_src_b),
		.snk_b    (b2_snk_b),
		.decay    (decay2)
	);

	assign dac1                = dac1_q;
	assign dac2                = dac2_q;
	assign neg1                = neg1_q;
	assign neg2                = neg2_q;
	assign position            = pos_q;
	assign res_mode            = res_q;
	assign overcurrent_latched = ocp_q;

endmodule

// ==== core/stpdrv_pkg.sv ====
// Shared constants and types of the stepper translator and PWM regulator.
package stpdrv_pkg;

	localparam int unsigned SYS_CLK_HZ = 20_000_000;
	localparam int unsigned CLK_NS     = 1_000_000_000 / SYS_CLK_HZ;

	// Blank time and fixed off-times in nanoseconds, then in clock cycles.
	localparam int unsigned BLANK_NS       = 1_000;
	localparam int unsigned OFF_GND_NS     = 16_000;
	localparam int unsigned OFF_HIGH_NS    = 30_000;
	localparam int unsigned BLANK_CYC      = BLANK_NS / CLK_NS;
	localparam int unsigned OFF_GND_CYC    = OFF_GND_NS / CLK_NS;
	localparam int unsigned OFF_HIGH_CYC   = OFF_HIGH_NS / CLK_NS;
	// Resistor option: off-time in us equals ohms divided by this figure.
	localparam int unsigned RES_DIVISOR    = 825;
	localparam int unsigned NS_PER_US      = 1_000;

	// Percent of mixed decay spent in fast decay, as 31.25 = 3125/100.
	localparam int unsigned MIX_PCT_X100   = 3125;

	localparam int unsigned CNT_W = 16;
	localparam int unsigned POS_W = 7;
	localparam int unsigned LVL_W = 7;

	// Home position index and quarter-wave length at thirty-second resolution.
	localparam logic [POS_W-1:0] HOME_POS = 7'h00;
	localparam int unsigned      QTR_LEN  = 32;

	typedef enum logic [2:0] {
		STPDRV_FULL      = 3'h0,
		STPDRV_HALF      = 3'h1,
		STPDRV_SIXTEENTH = 3'h2,
		STPDRV_THIRTY2ND = 3'h3,
		STPDRV_FULL_MOD  = 3'h4,
		STPDRV_HALF_MOD  = 3'h5,
		STPDRV_QUARTER   = 3'h6,
		STPDRV_EIGHTH    = 3'h7
	} stpdrv_res_t;

	typedef enum logic [1:0] {
		STPDRV_CFG_GND      = 2'h0,
		STPDRV_CFG_RESISTOR = 2'h1,
		STPDRV_CFG_HIGH     = 2'h2
	} stpdrv_cfg_t;

	typedef enum logic [1:0] {
		STPDRV_DEC_SLOW  = 2'h0,
		STPDRV_DEC_MIXED = 2'h1,
		STPDRV_DEC_FAST  = 2'h2
	} stpdrv_decay_t;

endpackage

// ==== core/stpdrv_table.sv ====
// Sine lookup of both phase levels for a position at 1/32 resolution.
module stpdrv_table
	import stpdrv_pkg::*;
(
	// Position in 1/32 steps over the full electrical turn.
	input  wire logic [POS_W-1:0] pos,
	input  wire logic             full_torque,
	// Level in percent and polarity for each phase.
	output logic      [LVL_W-1:0] lvl1,
	output logic                  neg1,
	output logic      [LVL_W-1:0] lvl2,
	output logic                  neg2
);

	// Quarter-wave of sine in percent, one entry per 1/32 step.
	localparam logic [LVL_W-1:0] SINE [0:QTR_LEN] = '{
		7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h18, 7'h1D, 7'h22,
		7'h26, 7'h2A, 7'h2F, 7'h33, 7'h37, 7'h3B, 7'h3E, 7'h42,
		7'h46, 7'h49, 7'h4C, 7'h4F, 7'h52, 7'h55, 7'h57, 7'h59,
		7'h5B, 7'h5D, 7'h5F, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64,
		7'h64
	};

	logic [4:0] sub;
	logic [1:0] quad;
	logic [LVL_W-1:0] s_up;
	logic [LVL_W-1:0] s_dn;

	assign sub  = pos[4:0];
	assign quad = pos[6:5];
	assign s_up = SINE[sub];
	assign s_dn = SINE[6'd32 - {1'b0, sub}];

	// Full-torque modes put both phases at full level off the axes.
	always_comb begin
		lvl1 = s_dn;
		lvl2 = s_up;
		unique case (quad)
			2'h0: begin
				neg1 = 1'b0;
				neg2 = 1'b0;
			end
			2'h1: begin
				lvl1 = s_up;
				lvl2 = s_dn;
				neg1 = 1'b1;
				neg2 = 1'b0;
			end
			2'h2: begin
				neg1 = 1'b1;
				neg2 = 1'b1;
			end
			2'h3: begin
				lvl1 = s_up;
				lvl2 = s_dn;
				neg1 = 1'b0;
				neg2 = 1'b1;
			end
		endcase
		if (full_torque) begin
			lvl1 = (lvl1 == 7'h00) ? 7'h00 : 7'h64;
			lvl2 = (lvl2 == 7'h00) ? 7'h00 : 7'h64;
		end
	end

endmodule

// ==== core/stpdrv_bridge.sv ====
// Fixed off-time PWM regulator of one full bridge.
module stpdrv_bridge
	import stpdrv_pkg::*;
(
	// Clock and reset.
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	// Control.
	input  wire logic             run,
	input  wire logic             neg,
	input  wire logic             trip,
	input  wire logic             step_evt,
	input  wire logic             home,
	input  wire logic             rising,
	input  wire stpdrv_cfg_t      cfg,
	input  wire logic [CNT_W-1:0] off_cyc,
	// Gate drives: source and sink of both half bridges.
	output logic                  src_a,
	output logic                  snk_a,
	output logic                  src_b,
	output logic                  snk_b,
	output stpdrv_decay_t         decay
);

	typedef enum logic [1:0] {ST_DRIVE, ST_DECAY} stpdrv_pwm_t;

	stpdrv_pwm_t      st_q;
	stpdrv_decay_t    decay_q;
	logic [CNT_W-1:0] blank_q;
	logic [CNT_W-1:0] off_q;
	logic             adapt_q;
	logic             early_q;
	logic [CNT_W-1:0] fast_len;

	// Fast part of a mixed decay cycle: 31.25 percent of the off-time.
	assign fast_len = CNT_W'((32'(off_cyc) * MIX_PCT_X100) / 10000);
	assign decay    = decay_q;

	// Adaptive mode adds fast decay only after a trip right at blank end.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q    <= ST_DRIVE;
			blank_q <= CNT_W'(BLANK_CYC);
			off_q   <= '0;
			adapt_q <= 1'b0;
		end else if (!run) begin
			st_q    <= ST_DRIVE;
			blank_q <= CNT_W'(BLANK_CYC);
			off_q   <= '0;
		end else begin
			unique case (st_q)
				ST_DRIVE: begin
					if (blank_q != '0) begin
						blank_q <= blank_q - 1'b1;
					end else if (trip) begin
						st_q    <= ST_DECAY;
						off_q   <= off_cyc;
						blank_q <= CNT_W'(BLANK_CYC);
						adapt_q <= early_q;
					end
				end
				ST_DECAY: begin
					if (off_q <= 16'h0001) begin
						st_q    <= ST_DRIVE;
						blank_q <= CNT_W'(BLANK_CYC);
					end else begin
						off_q <= off_q - 1'b1;
					end
				end
			endcase
		end
	end

	// High in the first unblanked cycle; a trip then means overshoot.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			early_q <= 1'b0;
		end else begin
			early_q <= (st_q == ST_DRIVE) && (blank_q == 16'h0001);
		end
	end

	// Decay method chosen by the off-time configuration.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			decay_q <= STPDRV_DEC_MIXED;
		end else if (home) begin
			decay_q <= STPDRV_DEC_MIXED;
		end else if (step_evt) begin
			if (cfg == STPDRV_CFG_GND) begin
				decay_q <= adapt_q ? STPDRV_DEC_MIXED : STPDRV_DEC_SLOW;
			end else begin
				decay_q <= rising ? STPDRV_DEC_SLOW : STPDRV_DEC_MIXED;
			end
		end
	end

	logic fast_now;
	logic drv_on;
	assign drv_on   = run && (st_q == ST_DRIVE);
	assign fast_now = (st_q == ST_DECAY) && (decay_q != STPDRV_DEC_SLOW)
		&& (off_q > (off_cyc - fast_len));

	// Slow decay drops the source and turns both sinks on; mixed decay reverses the bridge for its fast part, then does the same as slow.
	always_comb begin
		src_a = 1'b0;
		snk_a = 1'b0;
		src_b = 1'b0;
		snk_b = 1'b0;
		if (drv_on) begin
			src_a = !neg;
			snk_b = !neg;
			src_b = neg;
			snk_a = neg;
		end else if (run && fast_now) begin
			src_a = neg;
			snk_b = neg;
			src_b = !neg;
			snk_a = !neg;
		end else if (run) begin
			snk_a = 1'b1;
			snk_b = 1'b1;
		end
	end

endmodule

// ==== bench/stpdrv_chk_assertions.sv ====
// Port checks of the stepper translator top, bound into the design.
module stpdrv_chk
	import stpdrv_pkg::*;
(
	// Clock, reset and controls.
	input wire logic             sys_clk,
	input wire logic             nrst,
	input wire logic             step_in,
	input wire logic             reset_in_n,
	input wire logic             sleep_n,
	input wire logic             disable_out,
	input wire logic             thermal_shutdown,
	input wire logic             overcurrent,
	input wire stpdrv_cfg_t      offtime_config_pin,
	// Translator and bridge one outputs.
	input wire logic [POS_W-1:0] position,
	input wire stpdrv_res_t      res_mode,
	input wire logic [LVL_W-1:0] dac1,
	input wire logic [LVL_W-1:0] dac2,
	input wire logic             neg1,
	input wire stpdrv_decay_t    decay1,
	input wire logic             overcurrent_latched,
	input wire logic             b1_src_a,
	input wire logic             b1_snk_a,
	input wire logic             b1_src_b,
	input wire logic             b1_snk_b
);
	timeunit 1ns;
	timeprecision 1ns;

	logic        live;
	logic        run_ok;
	logic        gates_on;
	logic [15:0] on_q;
	logic [15:0] off_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	assign live = reset_in_n && sleep_n && !thermal_shutdown && !overcurrent;
	// Bridge one checks only while it regulates a positive, nonzero level.
	assign run_ok = live && !disable_out && !overcurrent_latched && !neg1
		&& dac1 != 7'h00 && offtime_config_pin == STPDRV_CFG_GND;
	assign gates_on = b1_src_a | b1_snk_a | b1_src_b | b1_snk_b;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			on_q  <= 16'h0000;
			off_q <= 16'h0000;
		end else begin
			on_q  <= b1_src_a ? on_q + 16'h0001 : 16'h0000;
			off_q <= (b1_src_a || !run_ok) ? 16'h0000 : off_q + 16'h0001;
		end
	end

	sequence s_trip;
		run_ok && $past(run_ok) && $fell(b1_src_a);
	endsequence

	property p_step_adv;
		$rose(step_in) && live && !overcurrent_latched
			|=> position != $past(position);
	endproperty
	a_step_adv: assert property (p_step_adv) else $error("step lost");

	property p_hold;
		!$rose(step_in) && live |=> $stable(position) && $stable(res_mode);
	endproperty
	a_hold: assert property (p_hold) else $error("moved without step");

	property p_rst_home;
		!reset_in_n |=> position == HOME_POS;
	endproperty
	a_rst_home: assert property (p_rst_home) else $error("not home");

	property p_rst_off;
		!reset_in_n ##1 !reset_in_n |-> !gates_on;
	endproperty
	a_rst_off: assert property (p_rst_off) else $error("gates on");

	property p_dis_off;
		disable_out ##1 disable_out |-> !gates_on;
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("gates enabled");

	property p_fault_home;
		thermal_shutdown || overcurrent |=> position == HOME_POS;
	endproperty
	a_fault_home: assert property (p_fault_home) else $error("no home");

	property p_torque;
		res_mode inside {STPDRV_FULL, STPDRV_HALF} && $stable(position)
			&& $stable(res_mode) |-> dac1 inside {7'h00, 7'h64}
			&& dac2 inside {7'h00, 7'h64};
	endproperty
	a_torque: assert property (p_torque) else $error("bad level");

	property p_blank;
		s_trip |-> on_q >= 16'(BLANK_CYC - 2);
	endproperty
	a_blank: assert property (p_blank) else $error("trip in blank");

	property p_mixed;
		s_trip and decay1 == STPDRV_DEC_MIXED |-> !b1_snk_b;
	endproperty
	a_mixed: assert property (p_mixed) else $error("sink left on");

	property p_off_max;
		off_q <= 16'(OFF_GND_CYC + 4);
	endproperty
	a_off_max: assert property (p_off_max) else $error("no restart");
endmodule

bind stpdrv_top stpdrv_chk chk_u (.*);

// ==== bench/stpdrv_ctrl.sv ====
// Controller model that issues one step pulse per request.
module stpdrv_ctrl #(
	parameter int unsigned PULSE_CYC = 20
) (
	// Clock and request.
	input  wire logic sys_clk,
	input  wire logic go,
	// Step pulse towards the translator.
	output logic      step_in,
	output logic      busy
);
	timeunit 1ns;
	timeprecision 1ns;

	// Both phases last the minimum width, so pulses are as fast as allowed.
	logic [7:0] cnt_q = 8'h00;

	always_ff @(posedge sys_clk) begin
		if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
		else if (go)
			cnt_q <= 8'(2 * PULSE_CYC);
	end

	assign step_in = cnt_q > 8'(PULSE_CYC);
	assign busy    = cnt_q != 8'h00;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the stepper translator and PWM regulator.
module testbench
	import stpdrv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic             sys_clk = 1'b0, nrst = 1'b0, go = 1'b0;
	logic             step_in, busy, dir_in = 1'b0;
	logic             res_sel_bit0 = 1'b0, res_sel_bit1 = 1'b0;
	logic             res_sel_bit2 = 1'b0, reset_in_n = 1'b1;
	logic             disable_out = 1'b0, sleep_n = 1'b1;
	logic             thermal_shutdown = 1'b0, overcurrent = 1'b0;
	stpdrv_cfg_t      offtime_config_pin = STPDRV_CFG_GND;
	logic [19:0]      offtime_res_ohms = 20'h061A8;
	logic             sense_trip1 = 1'b0, sense_trip2 = 1'b0;
	logic [LVL_W-1:0] dac1, dac2;
	logic             neg1, neg2, overcurrent_latched;
	logic [POS_W-1:0] position;
	stpdrv_res_t      res_mode;
	stpdrv_decay_t    decay1, decay2;
	logic             b1_src_a, b1_snk_a, b1_src_b, b1_snk_b;
	logic             b2_src_a, b2_snk_a, b2_src_b, b2_snk_b;
	int               bad_count = 0, num_checks = 0, cyc = 0;
	wire              gates = |{b1_src_a, b1_snk_a, b1_src_b, b1_snk_b,
		b2_src_a, b2_snk_a, b2_src_b, b2_snk_b};

	stpdrv_ctrl ctrl_u (.sys_clk, .go, .step_in, .busy);
	stpdrv_top dut_u (.*);

	initial forever #25 sys_clk = ~sys_clk;

	// Whole run needs well under this many cycles.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi,
		input int g);
		num_checks++;
		if (g < lo || g > hi) begin
			bad_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic step_once();
		int n;
		n = 0;
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		@(posedge sys_clk);
		while (busy === 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		chk_rng("busy", 0, 99, n);
		tick(2);
	endtask

	task automatic t_home();
		chk_val("home", {HOME_POS, 7'h64, 7'h00}, {position, dac1, dac2});
		chk_val("decay", {STPDRV_DEC_MIXED, STPDRV_DEC_MIXED}, {decay1, decay2});
	endtask

	// Trip is held through the blank window to prove it is ignored there.
	task automatic t_pwm(input stpdrv_cfg_t c, input int exp);
		int n;
		n = 0;
		@(posedge sys_clk);
		reset_in_n <= 1'b0;
		offtime_config_pin <= c;
		@(posedge sys_clk);
		reset_in_n <= 1'b1;
		while (b1_src_a !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk_val("pair", 2'h3, {b1_src_a, b1_snk_b});
		sense_trip1 <= 1'b1;
		n = 0;
		while (b1_src_a === 1'b1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		chk_rng("drive", BLANK_CYC - 2, BLANK_CYC + 3, n);
		chk_val("sink_b", 16'h0000, b1_snk_b);
		sense_trip1 <= 1'b0;
		n = 0;
		while (b1_src_a !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		chk_rng("off", exp - 1, exp + 3, n);
	endtask

	// Each mode change lands on a position shared by old and new modes.
	task automatic t_modes();
		logic [2:0] codes [8];
		int         incs [8];
		logic [6:0] p;
		logic [2:0] prv;
		codes = '{3'h1, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h3};
		incs = '{16, 32, 32, 16, 8, 4, 2, 1};
		p = HOME_POS;
		prv = 3'h0;
		foreach (codes[i]) begin
			@(posedge sys_clk);
			{res_sel_bit2, res_sel_bit1, res_sel_bit0} <= codes[i];
			tick(3);
			chk_val("mode_hold", prv, res_mode);
			step_once();
			p = p + 7'(incs[i]);
			prv = codes[i];
			chk_val("position", p, position);
			chk_val("mode", codes[i], res_mode);
			if (codes[i] == 3'h0)
				chk_val("full", {7'h64, 7'h64, 2'h2},
					{dac1, dac2, neg1, neg2});
			if (codes[i] == 3'h1)
				chk_val("decay_up", STPDRV_DEC_SLOW, decay2);
			if (codes[i] == 3'h4)
				chk_val("decay_dn", {STPDRV_DEC_MIXED, STPDRV_DEC_MIXED},
					{decay1, decay2});
		end
	endtask

	task automatic t_dir();
		@(posedge sys_clk);
		dir_in <= 1'b1;
		tick(3);
		chk_val("dir_hold", 7'h6F, position);
		step_once();
		chk_val("ccw", 7'h6E, position);
		@(posedge sys_clk);
		reset_in_n <= 1'b0;
		step_once();
		chk_val("held", {HOME_POS, 1'b0}, {position, gates});
		@(posedge sys_clk);
		reset_in_n <= 1'b1;
		step_once();
		chk_val("wrap", 7'h7F, position);
		@(posedge sys_clk);
		dir_in <= 1'b0;
		disable_out <= 1'b1;
		step_once();
		step_once();
		chk_val("disabled", {7'h01, 1'b0}, {position, gates});
		@(posedge sys_clk);
		disable_out <= 1'b0;
	endtask

	task automatic t_fault();
		@(posedge sys_clk);
		thermal_shutdown <= 1'b1;
		@(posedge sys_clk);
		thermal_shutdown <= 1'b0;
		tick(2);
		chk_val("tsd", HOME_POS, position);
		step_once();
		@(posedge sys_clk);
		overcurrent <= 1'b1;
		@(posedge sys_clk);
		overcurrent <= 1'b0;
		tick(2);
		chk_val("ocp", {HOME_POS, 2'h2},
			{position, overcurrent_latched, gates});
		// Clear the latch first so that only sleep can hold the gates off.
		@(posedge sys_clk);
		reset_in_n <= 1'b0;
		@(posedge sys_clk);
		reset_in_n <= 1'b1;
		step_once();
		@(posedge sys_clk);
		sleep_n <= 1'b0;
		tick(3);
		chk_val("sleep", {HOME_POS, 2'h0},
			{position, overcurrent_latched, gates});
		@(posedge sys_clk);
		sleep_n <= 1'b1;
		tick(3);
		chk_val("wake", {HOME_POS, 2'h1},
			{position, overcurrent_latched, gates});
	endtask

	initial begin
		tick(3);
		nrst <= 1'b1;
		tick(2);
		t_home();
		t_pwm(STPDRV_CFG_GND, OFF_GND_CYC);
		t_pwm(STPDRV_CFG_HIGH, OFF_HIGH_CYC);
		t_pwm(STPDRV_CFG_RESISTOR,
			25000 * NS_PER_US / (RES_DIVISOR * CLK_NS));
		t_modes();
		t_dir();
		t_fault();
		stop_test();
	end
endmodule
